// ---- lcap_pkg.sv ----
// Shared offsets, field positions and reset values of the link capabilities
package lcap_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [11:0] LCAP_OFS = 12'h04c;
  localparam logic [11:0] LCTL_OFS = 12'h050;
  localparam logic [11:0] UNLOCK_OFS = 12'h400;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Link capabilities field positions
  localparam int SPEED_LSB = 0;
  localparam int SPEED_MSB = 3;
  localparam int WIDTH_LSB = 4;
  localparam int WIDTH_MSB = 9;
  localparam int LPS_LSB = 10;
  localparam int LPS_MSB = 11;
  localparam int QEL_LSB = 12;
  localparam int QEL_MSB = 14;
  localparam int DEL_LSB = 15;
  localparam int DEL_MSB = 17;
  localparam int CLKRM_BIT = 18;
  localparam int SDROP_BIT = 19;
  localparam int LACT_BIT = 20;
  localparam int PORT_LSB = 24;
  localparam int PORT_MSB = 31;
  // Link control field positions
  localparam int ASPM_LSB = 0;
  localparam int ASPM_MSB = 1;
  localparam int REFCLK_BIT = 6;
  localparam int ESYNC_BIT = 7;
  // Unlock control field position
  localparam int UNLOCK_BIT = 0;
  // Field values
  localparam logic [3:0] SPEED_GEN1 = 4'h1;
  localparam logic [5:0] WIDTH_X1 = 6'h01;
  localparam logic [5:0] WIDTH_X2 = 6'h02;
  localparam logic [1:0] LPS_BOTH = 2'h3;
  localparam logic [2:0] QEL_SEPARATE = 3'h5;
  localparam logic [2:0] QEL_COMMON = 3'h3;
  localparam logic [2:0] DEL_RESET = 3'h2;
  localparam logic CLKRM_RESET = 1'b0;
  localparam logic [1:0] ASPM_RESET = 2'h0;
endpackage

// ---- lcap_top.sv ----
// Link capabilities register of one switch port, with link control
//
// Overview of operation
// R1 - Max speed field 3:0 reads 0x1 (2.5 Gbps), read-only.
// R2 - Max width field 9:4 starts at the port's physical width.
// R3 - Upstream port may override max width to train narrower.
// R4 - Reserved or invalid width code makes the link run as x1.
// R5 - Low-power support field 11:10 always reads 0x3, ignores writes.
// R6 - Quick exit latency reads 0x5 with separate reference clocks.
// R7 - Quick exit latency reads 0x3 with a common reference clock.
// R8 - Common clock comes from link control bit 6, written by software.
// R9 - Deep exit latency field 17:15 resets to 0x2.
// R10 - Clock removal bit 18 resets to zero.
// R11 - Surprise drop bit 19 resets 0 upstream, 1 downstream.
// R12 - Link active bit 20 resets 1 downstream, stays 0 upstream.
// R13 - Port index field 31:24 is read-only and returns the port number.
// R14 - Lockable fields written only while unlocked; bits 23:21 read zero.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module lcap_top #(
  parameter logic [7:0] PORT_NUM = 8'h00,
  parameter logic IS_UPSTREAM = 1'b1,
  parameter logic [5:0] PHYS_WIDTH = 6'h01
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [lcap_pkg::ADDR_W-1:0] addr_i,
  input wire logic [lcap_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [lcap_pkg::DATA_W-1:0] rdata_o,
  // Link side
  output logic [5:0] link_width_o,
  output logic shared_refclk_o,
  output logic [1:0] low_power_enable_o,
  output logic ext_sync_o
);
  localparam logic DOWN_CAP = ~IS_UPSTREAM;

  logic [5:0] max_width_ff;
  logic [2:0] deep_exit_ff;
  logic clock_removal_ff;
  logic surprise_drop_ff;
  logic link_active_ff;
  logic [1:0] aspm_ff;
  logic shared_refclk_ff;
  logic ext_sync_ff;
  logic unlock_ff;
  logic [lcap_pkg::DATA_W-1:0] rdata_ff;
  logic [lcap_pkg::DATA_W-1:0] nxt_rdata;
  logic [lcap_pkg::DATA_W-1:0] lcap_word;
  logic [lcap_pkg::DATA_W-1:0] lctl_word;
  logic [2:0] quick_exit;
  logic lcap_wr;
  logic lctl_wr;
  logic unlock_wr;

  lcap_width_if wif ();

  lcap_width_resolve #(
    .PHYS_WIDTH(PHYS_WIDTH)
  ) u_width (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wif(wif)
  );

  assign wif.width_code = max_width_ff;
  assign link_width_o = wif.lanes_eff; // see R4
  assign shared_refclk_o = shared_refclk_ff;
  assign low_power_enable_o = aspm_ff;
  assign ext_sync_o = ext_sync_ff;
  assign rdata_o = rdata_ff;

  // Lockable writes need the unlock bit set beforehand
  assign lcap_wr = wr_i && (addr_i == lcap_pkg::LCAP_OFS) && unlock_ff; // see R14
  assign lctl_wr = wr_i && (addr_i == lcap_pkg::LCTL_OFS);
  assign unlock_wr = wr_i && (addr_i == lcap_pkg::UNLOCK_OFS);

  // Latency follows the clocking software declared for this link
  assign quick_exit = shared_refclk_ff ? lcap_pkg::QEL_COMMON // see R7
                                       : lcap_pkg::QEL_SEPARATE; // see R6

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      unlock_ff <= 1'b0;
    end else if (unlock_wr) begin
      unlock_ff <= wdata_i[lcap_pkg::UNLOCK_BIT];
    end
  end

  // Only the upstream port may narrow its trained width
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      max_width_ff <= PHYS_WIDTH; // see R2
    end else if (lcap_wr && IS_UPSTREAM) begin
      max_width_ff <= wdata_i[lcap_pkg::WIDTH_MSB:lcap_pkg::WIDTH_LSB]; // see R3
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      deep_exit_ff <= lcap_pkg::DEL_RESET; // see R9
      clock_removal_ff <= lcap_pkg::CLKRM_RESET; // see R10
      surprise_drop_ff <= DOWN_CAP; // see R11
      link_active_ff <= DOWN_CAP; // see R12
    end else if (lcap_wr) begin
      deep_exit_ff <= wdata_i[lcap_pkg::DEL_MSB:lcap_pkg::DEL_LSB];
      clock_removal_ff <= wdata_i[lcap_pkg::CLKRM_BIT];
      surprise_drop_ff <= wdata_i[lcap_pkg::SDROP_BIT];
      // Upstream never reports link-active, whatever is written
      link_active_ff <= wdata_i[lcap_pkg::LACT_BIT] & DOWN_CAP; // see R12
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aspm_ff <= lcap_pkg::ASPM_RESET;
      shared_refclk_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
    end else if (lctl_wr) begin
      aspm_ff <= wdata_i[lcap_pkg::ASPM_MSB:lcap_pkg::ASPM_LSB];
      shared_refclk_ff <= wdata_i[lcap_pkg::REFCLK_BIT]; // see R8
      ext_sync_ff <= wdata_i[lcap_pkg::ESYNC_BIT];
    end
  end

  always_comb begin
    lcap_word = '0; // see R14
    lcap_word[lcap_pkg::SPEED_MSB:lcap_pkg::SPEED_LSB] =
      lcap_pkg::SPEED_GEN1; // see R1
    lcap_word[lcap_pkg::WIDTH_MSB:lcap_pkg::WIDTH_LSB] = max_width_ff;
    lcap_word[lcap_pkg::LPS_MSB:lcap_pkg::LPS_LSB] =
      lcap_pkg::LPS_BOTH; // see R5
    lcap_word[lcap_pkg::QEL_MSB:lcap_pkg::QEL_LSB] = quick_exit;
    lcap_word[lcap_pkg::DEL_MSB:lcap_pkg::DEL_LSB] = deep_exit_ff;
    lcap_word[lcap_pkg::CLKRM_BIT] = clock_removal_ff;
    lcap_word[lcap_pkg::SDROP_BIT] = surprise_drop_ff;
    lcap_word[lcap_pkg::LACT_BIT] = link_active_ff;
    lcap_word[lcap_pkg::PORT_MSB:lcap_pkg::PORT_LSB] = PORT_NUM; // see R13
  end

  always_comb begin
    lctl_word = '0;
    lctl_word[lcap_pkg::ASPM_MSB:lcap_pkg::ASPM_LSB] = aspm_ff;
    lctl_word[lcap_pkg::REFCLK_BIT] = shared_refclk_ff;
    lctl_word[lcap_pkg::ESYNC_BIT] = ext_sync_ff;
  end

  // Read data stand for exactly one cycle; unmapped reads give zero
  always_comb begin
    nxt_rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        lcap_pkg::LCAP_OFS: nxt_rdata = lcap_word;
        lcap_pkg::LCTL_OFS: nxt_rdata = lctl_word;
        lcap_pkg::UNLOCK_OFS: nxt_rdata[lcap_pkg::UNLOCK_BIT] = unlock_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
endmodule // lcap_top

// ---- lcap_top_props.sv ----
// Concurrent checks on the link capabilities register ports
`timescale 1ns/10ps
module lcap_top_props #(
  parameter logic [7:0] PORT_NUM = 8'h00,
  parameter logic IS_UPSTREAM = 1'b1,
  parameter logic [5:0] PHYS_WIDTH = 6'h01
) (
  // Clock, reset and register port
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Link side
  input wire logic [5:0] link_width_o,
  input wire logic shared_refclk_o,
  input wire logic [1:0] low_power_enable_o,
  input wire logic ext_sync_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic cap_rd;
  assign cap_rd = rd_i && addr_i == lcap_pkg::LCAP_OFS;
  property p_idle; !rd_i |=> rdata_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_speed; cap_rd |=> rdata_o[3:0] == 4'h1; endproperty
  a_speed: assert property (p_speed) else $error("bad speed");
  property p_lps; cap_rd |=> rdata_o[11:10] == 2'h3; endproperty
  a_lps: assert property (p_lps) else $error("bad lps");
  property p_port; cap_rd |=> rdata_o[31:24] == PORT_NUM; endproperty
  a_port: assert property (p_port) else $error("bad port");
  property p_resv; cap_rd |=> rdata_o[23:21] == 3'h0; endproperty
  a_resv: assert property (p_resv) else $error("bad resv");
  property p_qel;
    cap_rd |=> rdata_o[14:12] == ($past(shared_refclk_o) ? 3'h3 : 3'h5);
  endproperty
  a_qel: assert property (p_qel) else $error("bad qel");
  property p_shared_refclk_config;
    wr_i && addr_i == lcap_pkg::LCTL_OFS |=>
      shared_refclk_o == $past(wdata_i[6]);
  endproperty
  a_shared_refclk_config: assert property (p_shared_refclk_config) else $error("bad shared_refclk_config");
  property p_lw; link_width_o inside {6'h01, 6'h02}; endproperty
  a_lw: assert property (p_lw) else $error("bad width");
  property p_upact; IS_UPSTREAM && cap_rd |=> !rdata_o[20]; endproperty
  a_upact: assert property (p_upact) else $error("bad lact");
endmodule // lcap_top_props

// ---- lcap_top_tb.sv ----
// Self-checking bench for the link capabilities register
`timescale 1ns/10ps
module lcap_top_tb;
  logic clk_i, rst_i, wr_i, rd_i, shared_refclk_o, ext_sync_o;
  logic [11:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [5:0] link_width_o;
  logic [1:0] low_power_enable_o;
  int n_fail = 0, compares = 0, cyc = 0;
  logic [31:0] wv[3] = '{32'hffffffff, 32'h20, 32'h10};
  logic [31:0] rv[3] = '{32'h030fdff1, 32'h03005c21, 32'h03005c11};
  logic [5:0] lv[3] = '{6'h01, 6'h02, 6'h01};
  // Downstream twin: width override refused, bit 20 writable
  logic [31:0] dv[3] = '{32'h021fdc11, 32'h02005c11, 32'h02005c11};
  logic [31:0] rdata_dn;
  logic [5:0] width_dn;
  lcap_top #(.PORT_NUM(8'h03), .IS_UPSTREAM(1'b1), .PHYS_WIDTH(6'h02))
    lcap_top_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .link_width_o(link_width_o), .shared_refclk_o(shared_refclk_o),
    .low_power_enable_o(low_power_enable_o), .ext_sync_o(ext_sync_o));
  // Shares the register port so both ports see identical traffic
  lcap_top #(.PORT_NUM(8'h02), .IS_UPSTREAM(1'b0), .PHYS_WIDTH(6'h01))
    lcap_top_dn_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_dn),
    .link_width_o(width_dn), .shared_refclk_o(),
    .low_power_enable_o(), .ext_sync_o());
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Tests last about 55 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] m, logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk("rdata", e & m, rdata_o & m);
  endtask
  initial begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 12'h000;
    wdata_i = 32'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(12'h04c, '1, 32'h03015c21);
    chk("rdata_dn", 32'h02195c11, rdata_dn);
    chk("width", 32'h2, {26'h0, link_width_o});
    wr(12'h04c, 32'h0);
    rd(12'h04c, '1, 32'h03015c21);
    rd(12'h100, '1, 32'h0);
    $display("reset and lock test done");
    wr(12'h400, 32'h1);
    rd(12'h400, '1, 32'h1);
    foreach (wv[i]) begin
      wr(12'h04c, wv[i]);
      rd(12'h04c, '1, rv[i]);
      chk("width", {26'h0, lv[i]}, {26'h0, link_width_o});
      chk("rdata_dn", dv[i], rdata_dn);
      chk("width_dn", 32'h1, {26'h0, width_dn});
    end
    $display("width override test done");
    wr(12'h050, 32'hffffffff);
    rd(12'h050, '1, 32'hc3);
    chk("ctl", 32'hf, {28'h0, ext_sync_o, shared_refclk_o,
      low_power_enable_o});
    rd(12'h04c, 32'h7000, 32'h3000);
    wr(12'h050, 32'h0);
    rd(12'h04c, 32'h7000, 32'h5000);
    $display("common clock test done");
    wr(12'h400, 32'h0);
    wr(12'h04c, 32'h0);
    rd(12'h04c, '1, 32'h03005c11);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd(12'h04c, '1, 32'h03015c21);
    chk("rdata_dn", 32'h02195c11, rdata_dn);
    $display("relock and reset test done");
    finish_test();
  end
endmodule // lcap_top_tb
bind lcap_top lcap_top_props #(.PORT_NUM(PORT_NUM),
  .IS_UPSTREAM(IS_UPSTREAM), .PHYS_WIDTH(PHYS_WIDTH)) lcap_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link_width_o(link_width_o),
  .shared_refclk_o(shared_refclk_o), .ext_sync_o(ext_sync_o),
  .low_power_enable_o(low_power_enable_o));

// ---- lcap_width_if.sv ----
// Carries the width code to the resolver and the resolved lane count back
`timescale 1ns/10ps
interface lcap_width_if;
  logic [5:0] width_code;
  logic [5:0] lanes_eff;
  modport owner (output width_code, input lanes_eff);
  modport resolver (input width_code, output lanes_eff);
endinterface

// ---- lcap_width_resolve.sv ----
// Resolves the maximum-width code to the lane count used for training
`timescale 1ns/10ps
module lcap_width_resolve #(
  parameter logic [5:0] PHYS_WIDTH = 6'h01
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Width carrier
  lcap_width_if.resolver wif
);
  logic code_ok;

  // A x2 code is only meaningful where two lanes are really bonded
  always_comb begin
    code_ok = (wif.width_code == lcap_pkg::WIDTH_X1) ||
              ((wif.width_code == lcap_pkg::WIDTH_X2) &&
               (PHYS_WIDTH >= lcap_pkg::WIDTH_X2));
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wif.lanes_eff <= lcap_pkg::WIDTH_X1;
    end else begin
      wif.lanes_eff <= code_ok ? wif.width_code
                               : lcap_pkg::WIDTH_X1; // see R4
    end
  end
endmodule // lcap_width_resolve
